// ---- design/irq_expander_regs.svh ----
// constants for the peripheral interrupt expander and its cpu partner
`ifndef IRQ_EXPANDER_REGS_SVH
`define IRQ_EXPANDER_REGS_SVH

// ----------------------------------------------------------------
// cpu level vector addresses, table starting at zero
// ----------------------------------------------------------------
`define LEVEL_TABLE_BASE   16'h0000
`define LEVEL_FIVE_ADDR    16'h000A
`define LEVEL_SIX_ADDR     16'h000C

// ----------------------------------------------------------------
// bit positions in the request and acknowledge groups
// ----------------------------------------------------------------
`define GROUP_FIRST_BIT    7
`define SRC_COUNT          8
`define LEVEL_FIVE_MASK    8'h1F
`define LEVEL_SIX_MASK     8'hE0

// ----------------------------------------------------------------
// fixed event vectors
// ----------------------------------------------------------------
`define VEC_PHANTOM        16'h0000
`define VEC_SERIAL_PERIPH  16'h0005
`define VEC_SERIAL_RX      16'h0006
`define VEC_SERIAL_TX      16'h0007
`define VEC_CAN_MAILBOX    16'h0040
`define VEC_CAN_ERROR      16'h0041
`define VEC_CONVERTER      16'h0004
`define VEC_EXT_PIN_A      16'h0001
`define VEC_EXT_PIN_B      16'h0011
`define VEC_RESET_VALUE    16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REQ_PULSE_CYCLES   2'h2
`define CONTEXT_CYCLES     4'h3

`endif

// ---- design/irq_expander_pkg.sv ----
// types shared by both ends of the interrupt expander link
package irq_expander_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0]  src_vec_t;
	typedef logic [1:0]  level_vec_t;

	// cpu end handler sequence
	typedef enum logic [4:0] {
		CPU_IDLE = 5'h01,
		CPU_ACK  = 5'h02,
		CPU_SAVE = 5'h04,
		CPU_READ = 5'h08,
		CPU_RUN  = 5'h10
	} cpu_state_t;
endpackage

// ---- design/irq_link_if.sv ----
// link between the interrupt expander and the cpu interrupt logic
`timescale 1ns/1ps
`default_nettype none
interface irq_link_if;
	import irq_expander_pkg::*;
	// index 0 is level five, index 1 is level six; active low
	level_vec_t level_req_n;
	logic       ack;
	word_t      prog_addr_bus;
	logic       vec_rd;
	word_t      vec_data;

	modport dev (
		output level_req_n,
		input  ack,
		input  prog_addr_bus,
		input  vec_rd,
		output vec_data
	);
	modport cpu (
		input  level_req_n,
		output ack,
		output prog_addr_bus,
		output vec_rd,
		input  vec_data
	);
endinterface
`default_nettype wire

// ---- design/irq_expander.sv ----
// peripheral interrupt expander: low-priority levels five and six
`timescale 1ns/1ps
`default_nettype none
`include "irq_expander_regs.svh"

// Summary of operation
// - serial periph and rx on level five
// - serial tx bit 1.9 on level five
// - can mailbox bit 1.10, vector 0040h
// - can error bit 1.11, vector 0041h
// - converter and pins on level six
// - cpu drives level address with acknowledge
// - acknowledge clears the serviced pending request
// - acknowledge loads event vector into register
// - vectors are fixed constants, no setup
// - acknowledge without request loads phantom vector
// - flag cleared before acknowledge gives phantom
// - software interrupt acknowledge with none pending on its level gives phantom vector
// - nonmaskable sources never pass this block
// - cpu masks interrupts when servicing levels
// - cpu reads vector before re-enabling interrupts
// - level vector table starts at zero
// - handler saves context then reads vector
// - two-cycle low request pulse per level
// - flag and enable reach controller immediately
module irq_expander
	import irq_expander_pkg::*;
#(
	parameter int SRC_N = `SRC_COUNT
) (
	input  wire logic     clock_in,
	input  wire logic     rst_in,
	irq_link_if.dev       link,
	input  wire src_vec_t event_flag_in,
	input  wire src_vec_t event_enable_in,
	output logic [15:0]   periph_request_group_out,
	output logic [15:0]   periph_ack_group_out,
	output word_t         event_vector_reg_out,
	output logic          phantom_out
);

	// ------------------------------------------------------------
	// fixed vector table and level membership
	// ------------------------------------------------------------
	function automatic word_t vector_of(input logic [2:0] idx);
		case (idx)
			3'h0: vector_of = `VEC_SERIAL_PERIPH;
			3'h1: vector_of = `VEC_SERIAL_RX;
			3'h2: vector_of = `VEC_SERIAL_TX;
			3'h3: vector_of = `VEC_CAN_MAILBOX;
			3'h4: vector_of = `VEC_CAN_ERROR;
			3'h5: vector_of = `VEC_CONVERTER;
			3'h6: vector_of = `VEC_EXT_PIN_A;
			3'h7: vector_of = `VEC_EXT_PIN_B;
			default: vector_of = `VEC_PHANTOM;
		endcase
	endfunction

	function automatic src_vec_t level_mask(input logic lvl);
		if (lvl) begin
			level_mask = `LEVEL_SIX_MASK;
		end else begin
			level_mask = `LEVEL_FIVE_MASK;
		end
	endfunction

	// lowest index is highest overall priority
	function automatic logic [2:0] first_set(input src_vec_t v);
		first_set = 3'h0;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 3'(i);
			end
		end
	endfunction

	// ------------------------------------------------------------
	// request gathering
	// ------------------------------------------------------------
	src_vec_t periph_irq_request;
	src_vec_t served_r;
	src_vec_t pending;

	// combinational so a late enable is seen in the same cycle
	assign periph_irq_request = event_flag_in & event_enable_in;
	// a served source stays quiet until its flag or enable drops
	assign pending = periph_irq_request & ~served_r;

	// ------------------------------------------------------------
	// acknowledge decode
	// ------------------------------------------------------------
	logic       ack_hit;
	logic       ack_lvl;
	src_vec_t   ack_cand;
	logic       ack_found;
	logic [2:0] ack_idx;

	// only maskable levels five and six decode; other addresses,
	// nonmaskable ones included, are ignored here
	always_comb begin
		ack_hit = 1'b0;
		ack_lvl = 1'b0;
		if (link.ack) begin
			if (link.prog_addr_bus == `LEVEL_FIVE_ADDR) begin
				ack_hit = 1'b1;
			end else if (link.prog_addr_bus == `LEVEL_SIX_ADDR) begin
				ack_hit = 1'b1;
				ack_lvl = 1'b1;
			end
		end
	end

	assign ack_cand  = pending & level_mask(ack_lvl);
	assign ack_found = |ack_cand;
	assign ack_idx   = first_set(ack_cand);

	// ------------------------------------------------------------
	// served sources
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			served_r <= '0;
		end else begin
			for (int i = 0; i < SRC_N; i++) begin
				if (ack_hit && ack_found && ack_idx == 3'(i)) begin
					served_r[i] <= 1'b1;
				end else if (!periph_irq_request[i]) begin
					served_r[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// vector register
	// ------------------------------------------------------------
	word_t vector_r;
	logic  phantom_r;

	// reads have no side effect; only an acknowledge reloads
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			vector_r  <= `VEC_RESET_VALUE;
			phantom_r <= 1'b0;
		end else if (ack_hit) begin
			if (ack_found) begin
				vector_r  <= vector_of(ack_idx);
				phantom_r <= 1'b0;
			end else begin
				// software interrupt or flag cleared before ack
				vector_r  <= `VEC_PHANTOM;
				phantom_r <= 1'b1;
			end
		end
	end

	assign link.vec_data        = vector_r;
	assign event_vector_reg_out = vector_r;
	assign phantom_out          = phantom_r;

	// ------------------------------------------------------------
	// group status and acknowledge pulses toward peripherals
	// ------------------------------------------------------------
	logic [15:0] req_group_r;
	logic [15:0] ack_group_r;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			req_group_r <= 16'h0000;
		end else begin
			req_group_r <= 16'h0000;
			req_group_r[`GROUP_FIRST_BIT +: `SRC_COUNT] <= pending;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ack_group_r <= 16'h0000;
		end else begin
			ack_group_r <= 16'h0000;
			if (ack_hit && ack_found) begin
				ack_group_r[4'(ack_idx) + 4'(`GROUP_FIRST_BIT)] <= 1'b1;
			end
		end
	end

	assign periph_request_group_out = req_group_r;
	assign periph_ack_group_out     = ack_group_r;

	// ------------------------------------------------------------
	// cpu request pulse, one generator per level
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_level
			logic       outstanding_r;
			logic [1:0] pulse_cnt_r;
			logic       level_pend;
			logic       my_ack;
			logic       start;

			assign level_pend = |(pending & level_mask(1'(g)));
			assign my_ack     = ack_hit && (ack_lvl == 1'(g));
			// no new pulse while an earlier one waits for its ack
			assign start = level_pend && !outstanding_r
				&& (pulse_cnt_r == 2'h0);

			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					outstanding_r <= 1'b0;
				end else if (start) begin
					outstanding_r <= 1'b1;
				end else if (my_ack) begin
					outstanding_r <= 1'b0;
				end
			end

			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					pulse_cnt_r <= 2'h0;
				end else if (start) begin
					pulse_cnt_r <= `REQ_PULSE_CYCLES;
				end else if (pulse_cnt_r != 2'h0) begin
					pulse_cnt_r <= pulse_cnt_r - 2'h1;
				end
			end

			assign link.level_req_n[g] = (pulse_cnt_r == 2'h0);
		end
	endgenerate

endmodule
`default_nettype wire

// ---- design/irq_cpu_end.sv ----
// cpu-side interrupt acknowledge and handler sequencing
`timescale 1ns/1ps
`default_nettype none
`include "irq_expander_regs.svh"

module irq_cpu_end
	import irq_expander_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	irq_link_if.cpu         link,
	input  wire level_vec_t level_enable_in,
	input  wire logic       swi_valid_in,
	input  wire logic       swi_level_in,
	input  wire logic       irq_return_in,
	output logic            intm_out,
	output logic            handler_busy_out,
	output logic            served_level_out,
	output word_t           event_vector_out,
	output logic            event_valid_out
);

	// ------------------------------------------------------------
	// level flags, set on the falling edge of each request
	// ------------------------------------------------------------
	cpu_state_t state_r;
	level_vec_t req_prev_r;
	level_vec_t flag_r;
	logic       intm_r;
	logic       lvl_r;
	logic [3:0] save_cnt_r;
	word_t      addr_r;
	word_t      vec_r;
	logic       valid_r;
	level_vec_t fall;
	level_vec_t take;

	assign fall = req_prev_r & ~link.level_req_n;
	assign take = flag_r & level_enable_in;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			req_prev_r <= 2'h3;
		end else begin
			req_prev_r <= link.level_req_n;
		end
	end

	// a new request wins over the clear of the same flag
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			flag_r <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (fall[i]) begin
					flag_r[i] <= 1'b1;
				end else if (state_r == CPU_ACK && lvl_r == i[0]) begin
					flag_r[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// handler sequence
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_r    <= CPU_IDLE;
			lvl_r      <= 1'b0;
			addr_r     <= `LEVEL_TABLE_BASE;
			save_cnt_r <= 4'h0;
		end else begin
			case (state_r)
				CPU_IDLE: begin
					if (swi_valid_in) begin
						lvl_r   <= swi_level_in;
						state_r <= CPU_ACK;
						addr_r  <= swi_level_in ? `LEVEL_SIX_ADDR
							: `LEVEL_FIVE_ADDR;
					end else if (!intm_r && |take) begin
						// level five outranks level six
						lvl_r   <= !take[0];
						state_r <= CPU_ACK;
						addr_r  <= take[0] ? `LEVEL_FIVE_ADDR
							: `LEVEL_SIX_ADDR;
					end
				end
				CPU_ACK: begin
					save_cnt_r <= `CONTEXT_CYCLES;
					state_r    <= CPU_SAVE;
				end
				CPU_SAVE: begin
					if (save_cnt_r == 4'h1) begin
						state_r <= CPU_READ;
					end
					save_cnt_r <= save_cnt_r - 4'h1;
				end
				CPU_READ: begin
					state_r <= CPU_RUN;
				end
				CPU_RUN: begin
					if (irq_return_in) begin
						state_r <= CPU_IDLE;
					end
				end
				default: begin
					state_r <= CPU_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// global mask; return accepted in idle or after the vector is read
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			intm_r <= 1'b1;
		end else if (state_r == CPU_ACK) begin
			intm_r <= 1'b1;
		end else if (state_r == CPU_RUN && irq_return_in) begin
			intm_r <= 1'b0;
		end else if (state_r == CPU_IDLE && irq_return_in) begin
			intm_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			vec_r   <= `VEC_PHANTOM;
			valid_r <= 1'b0;
		end else begin
			valid_r <= (state_r == CPU_READ);
			if (state_r == CPU_READ) begin
				vec_r <= link.vec_data;
			end
		end
	end

	assign link.ack           = (state_r == CPU_ACK);
	assign link.prog_addr_bus = addr_r;
	assign link.vec_rd        = (state_r == CPU_READ);
	assign intm_out           = intm_r;
	assign handler_busy_out   = (state_r != CPU_IDLE);
	assign served_level_out   = lvl_r;
	assign event_vector_out   = vec_r;
	assign event_valid_out    = valid_r;

endmodule
`default_nettype wire

// ---- tb/irq_link_asserts.sv ----
// concurrent checks on the expander to cpu link
`timescale 1ns/1ps
`default_nettype none
module irq_link_asserts
	import irq_expander_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire level_vec_t level_req_n,
	input  wire logic       ack,
	input  wire word_t      prog_addr_bus,
	input  wire logic       vec_rd,
	input  wire word_t      vec_data
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	logic ack_five;
	logic ack_six;
	assign ack_five = ack && (prog_addr_bus == 16'h000A);
	assign ack_six  = ack && (prog_addr_bus == 16'h000C);

	// ------------------------------------------------------------
	// request pulses
	// ------------------------------------------------------------
	chk_pulse_five_two: assert property (
		$fell(level_req_n[0]) |=> !level_req_n[0] ##1 level_req_n[0])
		else $error("level five pulse not two cycles");
	chk_pulse_six_two: assert property (
		$fell(level_req_n[1]) |=> !level_req_n[1] ##1 level_req_n[1])
		else $error("level six pulse not two cycles");

	// ------------------------------------------------------------
	// vectors
	// ------------------------------------------------------------
	chk_five_vector_set: assert property (
		ack_five |=> vec_data inside {16'h0000, 16'h0005, 16'h0006,
			16'h0007, 16'h0040, 16'h0041})
		else $error("level five vector outside its set");
	chk_six_vector_set: assert property (
		ack_six |=> vec_data inside {16'h0000, 16'h0004, 16'h0001, 16'h0011})
		else $error("level six vector outside its set");
	chk_vector_holds: assert property (
		!(ack_five || ack_six) |=> $stable(vec_data))
		else $error("vector changed without acknowledge");

	// ------------------------------------------------------------
	// cpu side sequencing
	// ------------------------------------------------------------
	chk_ack_level_addr: assert property (
		ack |-> (ack_five || ack_six))
		else $error("acknowledge without level address");
	chk_read_after_save: assert property (
		vec_rd |-> $past(ack, 4))
		else $error("vector read not four cycles after acknowledge");
	chk_read_before_ack: assert property (
		ack |=> (!ack && !vec_rd)[*3] ##1 (vec_rd && !ack))
		else $error("vector not read before next acknowledge");

	cover property (ack_five);
	cover property (ack_six);
	cover property ((ack_five || ack_six) ##1 vec_data == 16'h0000);
endmodule
`default_nettype wire

// ---- tb/peripheral_interrupt_expander_bench.sv ----
// self-checking bench joining the expander to its cpu end
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_expander_bench;
	import irq_expander_pkg::*;
	logic        clock_in     = 1'b0;
	logic        rst_in       = 1'b1;
	src_vec_t    event_flag   = 8'h00;
	src_vec_t    event_enable = 8'h00;
	level_vec_t  level_enable = 2'h0;
	logic        swi_valid    = 1'b0;
	logic        swi_level    = 1'b0;
	logic        irq_return   = 1'b0;
	logic [15:0] req_group;
	logic [15:0] ack_group;
	logic [15:0] last_ack     = 16'h0000;
	word_t       vec_reg;
	word_t       cpu_vec;
	logic        phantom;
	logic        intm;
	logic        valid;
	logic        served_level;
	logic        busy;
	int          err_count    = 0;
	int          n_checks     = 0;
	int          cycles       = 0;
	// phantom vector kept at index 8
	word_t       vt [9] = '{16'h0005, 16'h0006, 16'h0007, 16'h0040,
		16'h0041, 16'h0004, 16'h0001, 16'h0011, 16'h0000};

	always #25 clock_in = ~clock_in;

	irq_link_if irq_link_if_i ();
	irq_expander irq_expander_i (
		.clock_in(clock_in), .rst_in(rst_in), .link(irq_link_if_i),
		.event_flag_in(event_flag), .event_enable_in(event_enable),
		.periph_request_group_out(req_group),
		.periph_ack_group_out(ack_group),
		.event_vector_reg_out(vec_reg), .phantom_out(phantom));
	irq_cpu_end irq_cpu_end_i (
		.clock_in(clock_in), .rst_in(rst_in), .link(irq_link_if_i),
		.level_enable_in(level_enable), .swi_valid_in(swi_valid),
		.swi_level_in(swi_level), .irq_return_in(irq_return),
		.intm_out(intm), .handler_busy_out(busy),
		.served_level_out(served_level), .event_vector_out(cpu_vec),
		.event_valid_out(valid));
	irq_link_asserts irq_link_asserts_i (
		.clock_in(clock_in), .rst_in(rst_in),
		.level_req_n(irq_link_if_i.level_req_n),
		.ack(irq_link_if_i.ack),
		.prog_addr_bus(irq_link_if_i.prog_addr_bus),
		.vec_rd(irq_link_if_i.vec_rd), .vec_data(irq_link_if_i.vec_data));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	// ack group pulse is gone before the handler reads, so latch it
	always @(negedge clock_in) begin
		if (ack_group !== 16'h0000) begin
			last_ack = ack_group;
		end
	end

	// waits for the handler read, checks it, then returns from it
	task automatic serve(input int idx, input logic lvl);
		int k;
		k = 0;
		do begin
			@(negedge clock_in);
			k++;
		end while (valid !== 1'b1 && k < 200);
		check("handler read", {15'h0, valid}, 16'h0001);
		check("event vector", cpu_vec, vt[idx]);
		check("vector register", vec_reg, vt[idx]);
		check("phantom flag", {15'h0, phantom}, {15'h0, idx == 8});
		check("ack group", last_ack,
			(idx < 8) ? (16'h0080 << idx) : 16'h0000);
		check("served level", {15'h0, served_level}, {15'h0, lvl});
		check("mask during handler", {15'h0, intm}, 16'h0001);
		check("handler busy", {15'h0, busy}, 16'h0001);
		last_ack = 16'h0000;
		@(posedge clock_in);
		irq_return <= 1'b1;
		@(posedge clock_in);
		irq_return <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// hang guard
	// ------------------------------------------------------------
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		ticks(5);
		rst_in <= 1'b0;
		event_enable <= 8'hFF;
		level_enable <= 2'h3;
		ticks(2);
		irq_return <= 1'b1;
		ticks(1);
		irq_return <= 1'b0;
		// each source alone on its level
		for (int i = 0; i < 8; i++) begin
			event_flag <= 8'h01 << i;
			serve(i, i > 4);
			event_flag <= 8'h00;
			ticks(3);
		end
		// several pending: lowest index first, level five before six
		event_flag <= 8'h3C;
		serve(2, 1'b0);
		serve(3, 1'b0);
		serve(4, 1'b0);
		serve(5, 1'b1);
		event_flag <= 8'h00;
		ticks(3);
		// software interrupt on each level
		for (int l = 0; l < 2; l++) begin
			swi_level <= l[0];
			swi_valid <= 1'b1;
			ticks(1);
			swi_valid <= 1'b0;
			serve(8, l[0]);
		end
		// masked flag, late enable, then flag cleared before acknowledge
		level_enable <= 2'h0;
		event_enable <= 8'hBF;
		event_flag <= 8'h40;
		ticks(3);
		@(negedge clock_in);
		check("pending disabled", req_group, 16'h0000);
		@(posedge clock_in);
		event_enable <= 8'hFF;
		ticks(2);
		@(negedge clock_in);
		check("pending enabled", req_group, 16'h2000);
		@(posedge clock_in);
		event_flag <= 8'h00;
		ticks(3);
		level_enable <= 2'h3;
		serve(8, 1'b1);
		ticks(5);
		wrap_up();
	end
endmodule
`default_nettype wire
